// File: core/rof_offset_clamp.sv
// Range check and clamp of one signed offset word
`timescale 1ns/1ps

module rof_offset_clamp
	import rof_pkg::*;
#(
	parameter logic signed [15:0] MIN_VAL = 16'sh0000,
	parameter logic signed [15:0] MAX_VAL = 16'sh0000
)
(
	// Raw word
	input wire logic [15:0] rawWord,
	// Clamped word and range flag
	output logic [15:0] clampedWord,
	output logic outOfRange
);

	initial
	begin
		if (MIN_VAL > MAX_VAL)
			$error("rof_offset_clamp: empty range");
	end

	////////////////////////////////////////////////////////////////////////////
	// Clamp to the nearer limit
	always_comb
	begin
		if ($signed(rawWord) < MIN_VAL)
		begin
			clampedWord = MIN_VAL;
			outOfRange = 1'b1;
		end
		else if ($signed(rawWord) > MAX_VAL)
		begin
			clampedWord = MAX_VAL;
			outOfRange = 1'b1;
		end
		else
		begin
			clampedWord = rawWord;
			outOfRange = 1'b0;
		end
	end

endmodule

// File: core/rof_offset_regs.sv
// Reference trim and margin step registers with reference slewing
`timescale 1ns/1ps

// Overview of operation
// R1: Trim is signed count of 1.953 mV steps
// R2: Trim accepted from -64 to +63 steps
// R3: Out-of-range write clamps, raises alert and status
// R4: Loop follower: NACK, ignore, invalid-command, alert
// R5: Reference bounded by max, min and zero
// R6: Slew rate follows converter state
// R7: Store-all copies trim to nonvolatile storage
// R8: Margin high adds margin-high step
// R9: Margin-high accepted from 0 to 31 steps
// R10: Margin-high restores 0009h or 000Fh by selector
// R11: Margin low adds negative margin-low step
// R12: Margin-low accepted from -64 to -1 steps
// R13: Trim resets zero, high byte sign-extends
// R14: Margin-high low five bits, high byte zero
// R15: Margin-low sign and six bits, ones above
// R16: Margin-low restores FFF7h or FFF1h by selector
// R17: Word access, full sixteen bits returned
module rof_offset_regs
	import rof_pkg::*;
#(
	parameter int REF_W = 16
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Decoded PMBus word command
	input wire logic cmdValid,
	input wire logic cmdWrite,
	input wire logic [7:0] cmdCode,
	input wire logic [15:0] cmdWrData,
	// Command answer
	output logic rspValid,
	output logic rspNack,
	output logic [15:0] rspRdData,
	// Device configuration
	input wire logic loopFollower,
	input wire logic marginHighRestoreSelect,
	input wire logic marginLowRestoreSelect,
	// Nonvolatile store and restore
	input wire logic storeDefaultAll,
	input wire logic restoreDefaultAll,
	input wire logic [15:0] nvmTrimStored,
	output logic nvmTrimWrite,
	output logic [15:0] nvmTrimData,
	// Status events
	output logic smbAlertPulse,
	output logic cmlStatusSet,
	output logic invalidDataSet,
	output logic invalidCmdSet,
	// Reference control
	input rof_margin_t operationMargin,
	input rof_conv_t convState,
	input wire logic rateTick,
	input wire logic [REF_W-1:0] tonRiseStep,
	input wire logic [REF_W-1:0] transitionStep,
	input wire logic [REF_W-1:0] toffFallStep,
	input wire logic [REF_W-1:0] voutCommandRef,
	input wire logic [REF_W-1:0] voutMaxRef,
	input wire logic [REF_W-1:0] voutMinRef,
	// Error amplifier reference
	output logic [REF_W-1:0] errorAmpReference,
	output logic refSettled
);

	initial
	begin
		if (REF_W < 8 || REF_W > REG_W)
			$error("rof_offset_regs: REF_W must be 8 to 16");
	end

	////////////////////////////////////////////////////////////////////////////
	// Word assembly helpers
	// Trim reads sign-extended from its sign bit
	function automatic logic [15:0] trimWord(input logic sgn, input logic [TRIM_LOW_W-1:0] low);
		return {{(REG_W-TRIM_LOW_W){sgn}}, low}; // [R13]
	endfunction
	// Margin high reads zero above its field
	function automatic logic [15:0] mhiWord(input logic [MHI_LOW_W-1:0] low);
		return {{(REG_W-MHI_LOW_W){1'b0}}, low}; // [R14]
	endfunction
	// Margin low reads ones above its field
	function automatic logic [15:0] mloWord(input logic [MLO_LOW_W-1:0] low);
		return {{(REG_W-MLO_LOW_W){1'b1}}, low}; // [R15]
	endfunction
	// Sign extension of an offset word to the sum width
	function automatic logic signed [SUM_W-1:0] extOffset(input logic [15:0] w);
		return $signed({{(SUM_W-REG_W){w[15]}}, w});
	endfunction
	// Zero extension of a reference level to the sum width
	function automatic logic signed [SUM_W-1:0] extRef(input logic [REF_W-1:0] v);
		return $signed({{(SUM_W-REF_W){1'b0}}, v});
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register state
	logic trimSign_ff, nxt_trimSign;
	logic [TRIM_LOW_W-1:0] trimLow_ff, nxt_trimLow;
	logic [MHI_LOW_W-1:0] mhiLow_ff, nxt_mhiLow;
	logic [MLO_LOW_W-1:0] mloLow_ff, nxt_mloLow;
	logic restorePending_ff, nxt_restorePending;
	logic rspValid_ff, nxt_rspValid;
	logic rspNack_ff, nxt_rspNack;
	logic [15:0] rspRdData_ff, nxt_rspRdData;
	logic nvmTrimWrite_ff, nxt_nvmTrimWrite;
	logic [15:0] nvmTrimData_ff, nxt_nvmTrimData;
	logic alert_ff, nxt_alert;
	logic invalidData_ff, nxt_invalidData;
	logic invalidCmd_ff, nxt_invalidCmd;
	logic [15:0] trimValue, mhiValue, mloValue, wrTrimClamped, wrMhiClamped, wrMloClamped, nvmTrimClamped;
	logic wrTrimOor, wrMhiOor, wrMloOor, cmdHit;

	assign trimValue = trimWord(trimSign_ff, trimLow_ff);
	assign mhiValue = mhiWord(mhiLow_ff);
	assign mloValue = mloWord(mloLow_ff);
	assign cmdHit = cmdValid && (cmdCode == CMD_REF_TRIM || cmdCode == CMD_MARGIN_HIGH
		|| cmdCode == CMD_MARGIN_LOW);

	////////////////////////////////////////////////////////////////////////////
	// Range checks on the write data and on the stored trim
	rof_offset_clamp #(.MIN_VAL(TRIM_MIN), .MAX_VAL(TRIM_MAX)) uTrimClamp // [R2]
	(
		.rawWord(cmdWrData),
		.clampedWord(wrTrimClamped),
		.outOfRange(wrTrimOor)
	);
	rof_offset_clamp #(.MIN_VAL(MHI_MIN), .MAX_VAL(MHI_MAX)) uMhiClamp // [R9]
	(
		.rawWord(cmdWrData),
		.clampedWord(wrMhiClamped),
		.outOfRange(wrMhiOor)
	);
	rof_offset_clamp #(.MIN_VAL(MLO_MIN), .MAX_VAL(MLO_MAX)) uMloClamp // [R12]
	(
		.rawWord(cmdWrData),
		.clampedWord(wrMloClamped),
		.outOfRange(wrMloOor)
	);
	rof_offset_clamp #(.MIN_VAL(TRIM_MIN), .MAX_VAL(TRIM_MAX)) uNvmClamp
	(
		.rawWord(nvmTrimStored),
		.clampedWord(nvmTrimClamped),
		.outOfRange()
	);

	////////////////////////////////////////////////////////////////////////////
	// Command handling, restore and store: next values
	always_comb
	begin
		nxt_trimSign = trimSign_ff;
		nxt_trimLow = trimLow_ff;
		nxt_mhiLow = mhiLow_ff;
		nxt_mloLow = mloLow_ff;
		nxt_restorePending = 1'b0;
		nxt_rspValid = 1'b0;
		nxt_rspNack = 1'b0;
		nxt_rspRdData = rspRdData_ff;
		nxt_alert = 1'b0;
		nxt_invalidData = 1'b0;
		nxt_invalidCmd = 1'b0;
		// Copy of the trim word for nonvolatile storage
		nxt_nvmTrimWrite = storeDefaultAll; // [R7]
		nxt_nvmTrimData = storeDefaultAll ? trimValue : nvmTrimData_ff; // [R7]
		// Restore after reset release or on request
		if (restorePending_ff || restoreDefaultAll)
		begin
			nxt_trimSign = nvmTrimClamped[15];
			nxt_trimLow = nvmTrimClamped[TRIM_LOW_W-1:0];
			nxt_mhiLow = marginHighRestoreSelect ? MHI_RESTORE_SEL1[MHI_LOW_W-1:0]
				: MHI_RESTORE_SEL0[MHI_LOW_W-1:0]; // [R10]
			nxt_mloLow = marginLowRestoreSelect ? MLO_RESTORE_SEL1[MLO_LOW_W-1:0]
				: MLO_RESTORE_SEL0[MLO_LOW_W-1:0]; // [R16]
		end
		// A command taken in the same cycle wins over a restore
		if (cmdHit)
		begin
			nxt_rspValid = 1'b1;
			if (loopFollower)
			begin
				// Follower refuses every access and flags it
				nxt_rspNack = 1'b1; // [R4]
				nxt_invalidCmd = 1'b1; // [R4]
				nxt_alert = 1'b1; // [R4]
			end
			else if (cmdWrite)
			begin
				unique case (cmdCode)
					CMD_REF_TRIM:
					begin
						nxt_trimSign = wrTrimClamped[15]; // [R13]
						nxt_trimLow = wrTrimClamped[TRIM_LOW_W-1:0]; // [R13]
						nxt_invalidData = wrTrimOor; // [R3]
					end
					CMD_MARGIN_HIGH:
					begin
						nxt_mhiLow = wrMhiClamped[MHI_LOW_W-1:0]; // [R14]
						nxt_invalidData = wrMhiOor; // [R3]
					end
					default:
					begin
						nxt_mloLow = wrMloClamped[MLO_LOW_W-1:0]; // [R15]
						nxt_invalidData = wrMloOor; // [R3]
					end
				endcase
				nxt_alert = nxt_invalidData; // [R3]
			end
			else
			begin
				// Full word returned on a read
				unique case (cmdCode)
					CMD_REF_TRIM: nxt_rspRdData = trimValue; // [R17]
					CMD_MARGIN_HIGH: nxt_rspRdData = mhiValue; // [R17]
					default: nxt_rspRdData = mloValue; // [R17]
				endcase
			end
		end
	end

	// Command handling registers
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			trimSign_ff <= TRIM_RESET[15]; // [R13]
			trimLow_ff <= TRIM_RESET[TRIM_LOW_W-1:0]; // [R13]
			mhiLow_ff <= MHI_RESTORE_SEL0[MHI_LOW_W-1:0];
			mloLow_ff <= MLO_RESET[MLO_LOW_W-1:0];
			restorePending_ff <= 1'b1;
			rspValid_ff <= 1'b0;
			rspNack_ff <= 1'b0;
			rspRdData_ff <= 16'h0000;
			nvmTrimWrite_ff <= 1'b0;
			nvmTrimData_ff <= 16'h0000;
			alert_ff <= 1'b0;
			invalidData_ff <= 1'b0;
			invalidCmd_ff <= 1'b0;
		end
		else
		begin
			trimSign_ff <= nxt_trimSign;
			trimLow_ff <= nxt_trimLow;
			mhiLow_ff <= nxt_mhiLow;
			mloLow_ff <= nxt_mloLow;
			restorePending_ff <= nxt_restorePending;
			rspValid_ff <= nxt_rspValid;
			rspNack_ff <= nxt_rspNack;
			rspRdData_ff <= nxt_rspRdData;
			nvmTrimWrite_ff <= nxt_nvmTrimWrite;
			nvmTrimData_ff <= nxt_nvmTrimData;
			alert_ff <= nxt_alert;
			invalidData_ff <= nxt_invalidData;
			invalidCmd_ff <= nxt_invalidCmd;
		end
	end

	// Answer and event outputs
	assign rspValid = rspValid_ff;
	assign rspNack = rspNack_ff;
	assign rspRdData = rspRdData_ff;
	assign nvmTrimWrite = nvmTrimWrite_ff;
	assign nvmTrimData = nvmTrimData_ff;
	assign smbAlertPulse = alert_ff;
	assign cmlStatusSet = invalidData_ff || invalidCmd_ff; // [R3]
	assign invalidDataSet = invalidData_ff; // [R3]
	assign invalidCmdSet = invalidCmd_ff;

	////////////////////////////////////////////////////////////////////////////
	// Reference target and slewing
	logic [REF_W-1:0] ref_ff, nxt_ref;
	logic [REF_W-1:0] refTarget;
	// Next reference level
	always_comb
	begin
		logic signed [SUM_W-1:0] sum;
		logic signed [SUM_W-1:0] diff;
		logic signed [SUM_W-1:0] step;
		sum = '0;
		diff = '0;
		step = '0;
		// Nominal plus trim plus selected margin
		sum = extRef(voutCommandRef) + extOffset(trimValue); // [R1]
		unique case (operationMargin)
			OP_MARGIN_HIGH: sum = sum + extOffset(mhiValue); // [R8]
			OP_MARGIN_LOW: sum = sum + extOffset(mloValue); // [R11]
			default: sum = sum;
		endcase
		// Bound by the programmed maximum and minimum
		if (sum > extRef(voutMaxRef))
			sum = extRef(voutMaxRef); // [R5]
		if (sum < extRef(voutMinRef))
			sum = extRef(voutMinRef); // [R5]
		if (sum < 0)
			sum = '0; // [R5]
		// Off and soft-stop head to zero
		if (convState == CONV_OFF || convState == CONV_SOFT_STOP)
			refTarget = '0;
		else
			refTarget = sum[REF_W-1:0];
		// Rate picked by converter state
		unique case (convState)
			CONV_SOFT_START: step = extRef(tonRiseStep); // [R6]
			CONV_STEADY, CONV_TOFF_DELAY: step = extRef(transitionStep); // [R6]
			CONV_SOFT_STOP: step = extRef(toffFallStep); // [R6]
			default: step = '0;
		endcase
		diff = extRef(refTarget) - extRef(ref_ff);
		nxt_ref = ref_ff;
		if (convState == CONV_OFF)
			nxt_ref = '0;
		else if (rateTick)
		begin
			// Move one step toward the target without overshoot
			if (diff > step)
				nxt_ref = REF_W'(extRef(ref_ff) + step); // [R6]
			else if (diff < -step)
				nxt_ref = REF_W'(extRef(ref_ff) - step); // [R6]
			else
				nxt_ref = refTarget;
		end
	end

	// Reference register
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			ref_ff <= '0;
		else
			ref_ff <= nxt_ref;
	end

	assign errorAmpReference = ref_ff;
	assign refSettled = (ref_ff == refTarget);

endmodule

// File: core/rof_pkg.sv
// Shared constants and types for the reference offset and margin registers
package rof_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Command codes of the three offset registers
	localparam logic [7:0] CMD_REF_TRIM = 8'hD4;
	localparam logic [7:0] CMD_MARGIN_HIGH = 8'hD5;
	localparam logic [7:0] CMD_MARGIN_LOW = 8'hD6;

	////////////////////////////////////////////////////////////////////////////
	// Word format: linear, exponent fixed, one step per mantissa count
	localparam int VOUT_EXPONENT = -9;
	localparam int OFFSET_STEP_UV = 1953;
	localparam int REG_W = 16;
	localparam int SUM_W = 18;

	////////////////////////////////////////////////////////////////////////////
	// Writable field widths
	localparam int TRIM_LOW_W = 7;
	localparam int MHI_LOW_W = 5;
	localparam int MLO_LOW_W = 6;

	////////////////////////////////////////////////////////////////////////////
	// Accepted ranges, in steps
	localparam logic signed [15:0] TRIM_MIN = 16'shFFC0;
	localparam logic signed [15:0] TRIM_MAX = 16'sh003F;
	localparam logic signed [15:0] MHI_MIN = 16'sh0000;
	localparam logic signed [15:0] MHI_MAX = 16'sh001F;
	localparam logic signed [15:0] MLO_MIN = 16'shFFC0;
	localparam logic signed [15:0] MLO_MAX = 16'shFFFF;

	////////////////////////////////////////////////////////////////////////////
	// Reset and restore values
	localparam logic [15:0] TRIM_RESET = 16'h0000;
	localparam logic [15:0] MHI_RESTORE_SEL0 = 16'h0009;
	localparam logic [15:0] MHI_RESTORE_SEL1 = 16'h000F;
	localparam logic [15:0] MLO_RESTORE_SEL0 = 16'hFFF7;
	localparam logic [15:0] MLO_RESTORE_SEL1 = 16'hFFF1;
	localparam logic [15:0] MLO_RESET = 16'hFFFF;

	////////////////////////////////////////////////////////////////////////////
	// Converter power state, picks the slew rate
	typedef enum logic [2:0]
	{
		CONV_OFF = 3'b000,
		CONV_SOFT_START = 3'b001,
		CONV_STEADY = 3'b010,
		CONV_TOFF_DELAY = 3'b011,
		CONV_SOFT_STOP = 3'b100
	} rof_conv_t;

	// Margin state selected by the operation command
	typedef enum logic [1:0]
	{
		OP_NOMINAL = 2'b00,
		OP_MARGIN_LOW = 2'b01,
		OP_MARGIN_HIGH = 2'b10
	} rof_margin_t;

endpackage

// File: sim/rof_host_model.sv
// Host model issuing decoded word commands
`timescale 1ns/1ps

module rof_host_model
(
	// Clock
	input wire logic ref_clk,
	// Command port
	output logic cmdValid,
	output logic cmdWrite,
	output logic [7:0] cmdCode,
	output logic [15:0] cmdWrData
);
	// Idle levels
	initial
	begin
		cmdValid = 1'b0;
		cmdWrite = 1'b0;
		cmdCode = 8'h00;
		cmdWrData = 16'h0000;
	end

	// Whole word held for one taking edge, stale data inverted after
	task cmd(input logic wr, input logic [7:0] code, input logic [15:0] data);
		@(negedge ref_clk);
		cmdValid = 1'b1;
		cmdWrite = wr;
		cmdCode = code;
		cmdWrData = data;
		@(negedge ref_clk);
		cmdValid = 1'b0;
		cmdWrData = ~data;
	endtask
endmodule

// File: sim/rof_offset_regs_assertions.sv
// Port checker of the offset register block
`timescale 1ns/1ps

module rof_offset_regs_chk
	import rof_pkg::*;
#(
	parameter int REF_W = 16
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Requests
	input wire logic cmdValid,
	input wire logic cmdWrite,
	input wire logic [7:0] cmdCode,
	input wire logic [15:0] cmdWrData,
	input wire logic loopFollower,
	input wire logic storeDefaultAll,
	input rof_conv_t convState,
	// Answers and events
	input wire logic rspValid,
	input wire logic rspNack,
	input wire logic smbAlertPulse,
	input wire logic cmlStatusSet,
	input wire logic invalidDataSet,
	input wire logic invalidCmdSet,
	input wire logic nvmTrimWrite,
	input wire logic [REF_W-1:0] errorAmpReference
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////////
	// Decode of commands aimed at this block
	wire isOurs = cmdValid && (cmdCode == CMD_REF_TRIM || cmdCode == CMD_MARGIN_HIGH || cmdCode == CMD_MARGIN_LOW);
	wire wrOk = isOurs && cmdWrite && !loopFollower;
	wire signed [15:0] sData = cmdWrData;

	////////////////////////////////////////////////////////////////////////////
	// Answer timing and refusal
	chk_answer_delay: assert property (isOurs |=> rspValid)
		else $error("no answer one cycle after command");
	chk_foreign_quiet: assert property (!isOurs |=> !rspValid)
		else $error("answer without a command");
	chk_follower_refuse: assert property (isOurs && loopFollower
		|=> rspNack && smbAlertPulse && cmlStatusSet && invalidCmdSet)
		else $error("follower access not refused");
	chk_leader_accept: assert property (isOurs && !loopFollower |=> !rspNack && !invalidCmdSet)
		else $error("leader access refused");
	chk_nack_pair: assert property (rspNack |-> rspValid)
		else $error("refusal without answer");
	// Range checks on written words
	chk_trim_range: assert property (wrOk && cmdCode == CMD_REF_TRIM && (sData > 63 || sData < -64)
		|=> invalidDataSet && smbAlertPulse && cmlStatusSet)
		else $error("trim out of range not flagged");
	chk_high_inrange: assert property (wrOk && cmdCode == CMD_MARGIN_HIGH && sData >= 0 && sData <= 31
		|=> !invalidDataSet)
		else $error("good margin high flagged");
	chk_high_range: assert property (wrOk && cmdCode == CMD_MARGIN_HIGH && (sData > 31 || sData < 0)
		|=> invalidDataSet && smbAlertPulse)
		else $error("margin high out of range not flagged");
	chk_low_range: assert property (wrOk && cmdCode == CMD_MARGIN_LOW && (sData > -1 || sData < -64)
		|=> invalidDataSet)
		else $error("margin low out of range not flagged");
	// Store and power-off reference
	chk_store_copy: assert property (storeDefaultAll |=> nvmTrimWrite)
		else $error("store did not write trim");
	chk_off_zero: assert property ((convState == CONV_OFF) [*2] |-> errorAmpReference == '0)
		else $error("reference not zero when off");
endmodule

bind rof_offset_regs rof_offset_regs_chk #(.REF_W(REF_W)) chk_inst (.ref_clk, .sys_rst, .cmdValid, .cmdWrite, .cmdCode,
	.cmdWrData, .loopFollower, .storeDefaultAll, .convState, .rspValid, .rspNack, .smbAlertPulse, .cmlStatusSet,
	.invalidDataSet, .invalidCmdSet, .nvmTrimWrite, .errorAmpReference);

// File: sim/tb.sv
// Self-checking bench of the offset register block
`timescale 1ns/1ps

module tb
	import rof_pkg::*;
;
	logic ref_clk, sys_rst, cmdValid, cmdWrite, rspValid, rspNack, loopFollower, rateTick, refSettled;
	logic marginHighRestoreSelect, marginLowRestoreSelect, storeDefaultAll, restoreDefaultAll, nvmTrimWrite;
	logic smbAlertPulse, cmlStatusSet, invalidDataSet, invalidCmdSet;
	logic [7:0] cmdCode;
	logic [15:0] cmdWrData, rspRdData, nvmTrimStored, nvmTrimData, tonRiseStep, transitionStep, toffFallStep;
	logic [15:0] voutCommandRef, voutMaxRef, voutMinRef, errorAmpReference;
	rof_margin_t operationMargin;
	rof_conv_t convState;
	int badCount, nTests, cycles;
	wire [15:0] evt = {10'h000, rspValid, rspNack, smbAlertPulse, cmlStatusSet, invalidDataSet, invalidCmdSet};
	// Rows: expected events, code, written word, word read back
	logic [47:0] rows [12] = '{48'h20D4003F003F, 48'h20D4FFC0FFC0, 48'h2ED40040003F, 48'h2ED4FFBFFFC0,
		48'h2ED48000FFC0, 48'h20D5001F001F, 48'h2ED50040001F, 48'h2ED5FFFF0000, 48'h20D6FFC0FFC0,
		48'h2ED60000FFFF, 48'h2ED6FFBFFFC0, 48'h2ED67FFFFFFF};

	rof_offset_regs #(.REF_W(16)) rof_offset_regs_inst (.ref_clk, .sys_rst, .cmdValid, .cmdWrite, .cmdCode,
		.cmdWrData, .rspValid, .rspNack, .rspRdData, .loopFollower, .marginHighRestoreSelect,
		.marginLowRestoreSelect, .storeDefaultAll, .restoreDefaultAll, .nvmTrimStored, .nvmTrimWrite,
		.nvmTrimData, .smbAlertPulse, .cmlStatusSet, .invalidDataSet, .invalidCmdSet, .operationMargin,
		.convState, .rateTick, .tonRiseStep, .transitionStep, .toffFallStep, .voutCommandRef, .voutMaxRef,
		.voutMinRef, .errorAmpReference, .refSettled);
	rof_host_model rof_host_model_inst (.ref_clk, .cmdValid, .cmdWrite, .cmdCode, .cmdWrData);

	////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			badCount++;
			reportAndStop();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		nTests++;
		if (seen !== exp)
		begin
			badCount++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task rst(input logic sel, input logic [15:0] nvm);
		@(negedge ref_clk);
		sys_rst = 1'b1;
		marginHighRestoreSelect = sel;
		marginLowRestoreSelect = ~sel;
		nvmTrimStored = nvm;
		repeat (10) @(negedge ref_clk);
		sys_rst = 1'b0;
		repeat (2) @(negedge ref_clk);
	endtask

	task refCase(input rof_margin_t m, input rof_conv_t st, input logic [15:0] exp);
		operationMargin = m;
		convState = st;
		rateTick = 1'b1;
		@(negedge ref_clk);
		rateTick = 1'b0;
		@(negedge ref_clk);
		chk(errorAmpReference, exp);
	endtask

	task reportAndStop;
		$display("Comparisons %0d, mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		sys_rst = 1'b1;
		{loopFollower, rateTick, storeDefaultAll, restoreDefaultAll} = 4'h0;
		{marginHighRestoreSelect, marginLowRestoreSelect} = 2'h0;
		nvmTrimStored = 16'h0000;
		operationMargin = OP_NOMINAL;
		convState = CONV_STEADY;
		tonRiseStep = 16'h0004;
		transitionStep = 16'h0400;
		toffFallStep = 16'h0002;
		voutCommandRef = 16'h0100;
		voutMaxRef = 16'h0200;
		voutMinRef = 16'h0050;
		rst(1'b0, 16'h0000);
		// Write each row, then read it back
		for (int i = 0; i < 12; i++)
		begin
			rof_host_model_inst.cmd(1'b1, rows[i][39:32], rows[i][31:16]);
			chk(evt, {8'h00, rows[i][47:40]});
			rof_host_model_inst.cmd(1'b0, rows[i][39:32], 16'h0000);
			chk(rspRdData, rows[i][15:0]);
		end
		// Restore values for both selector settings
		for (int s = 0; s < 2; s++)
		begin
			rst(s[0], s[0] ? 16'hFF80 : 16'h0045);
			rof_host_model_inst.cmd(1'b0, CMD_REF_TRIM, 16'h0000);
			chk(rspRdData, s[0] ? 16'hFFC0 : 16'h003F);
			rof_host_model_inst.cmd(1'b0, CMD_MARGIN_HIGH, 16'h0000);
			chk(rspRdData, s[0] ? 16'h000F : 16'h0009);
			rof_host_model_inst.cmd(1'b0, CMD_MARGIN_LOW, 16'h0000);
			chk(rspRdData, s[0] ? 16'hFFF7 : 16'hFFF1);
		end
		// Follower refuses both directions, foreign code ignored
		loopFollower = 1'b1;
		rof_host_model_inst.cmd(1'b1, CMD_MARGIN_HIGH, 16'h0003);
		chk(evt, 16'h003D);
		rof_host_model_inst.cmd(1'b0, CMD_MARGIN_LOW, 16'h0000);
		chk(evt, 16'h003D);
		loopFollower = 1'b0;
		rof_host_model_inst.cmd(1'b0, CMD_MARGIN_HIGH, 16'h0000);
		chk(rspRdData, 16'h000F);
		rof_host_model_inst.cmd(1'b1, 8'hD7, 16'h0001);
		chk(evt, 16'h0000);
		// Restore pulse overrides a written step
		rof_host_model_inst.cmd(1'b1, CMD_MARGIN_HIGH, 16'h0001);
		restoreDefaultAll = 1'b1;
		@(negedge ref_clk);
		restoreDefaultAll = 1'b0;
		rof_host_model_inst.cmd(1'b0, CMD_MARGIN_HIGH, 16'h0000);
		chk(rspRdData, 16'h000F);
		// Store copies trim out
		rof_host_model_inst.cmd(1'b1, CMD_REF_TRIM, 16'hFFC5);
		storeDefaultAll = 1'b1;
		@(negedge ref_clk);
		storeDefaultAll = 1'b0;
		chk({nvmTrimWrite, nvmTrimData[14:0]}, 16'hFFC5);
		// Reference target and slewing
		rof_host_model_inst.cmd(1'b1, CMD_REF_TRIM, 16'h0005);
		rof_host_model_inst.cmd(1'b1, CMD_MARGIN_HIGH, 16'h0010);
		rof_host_model_inst.cmd(1'b1, CMD_MARGIN_LOW, 16'hFFF0);
		refCase(OP_NOMINAL, CONV_STEADY, 16'h0105);
		refCase(OP_MARGIN_HIGH, CONV_STEADY, 16'h0115);
		refCase(OP_MARGIN_LOW, CONV_STEADY, 16'h00F5);
		refCase(OP_MARGIN_HIGH, CONV_SOFT_START, 16'h00F9);
		chk(16'(refSettled), 16'h0000);
		refCase(OP_MARGIN_HIGH, CONV_TOFF_DELAY, 16'h0115);
		refCase(OP_MARGIN_HIGH, CONV_SOFT_STOP, 16'h0113);
		voutMaxRef = 16'h0100;
		refCase(OP_MARGIN_HIGH, CONV_STEADY, 16'h0100);
		chk(16'(refSettled), 16'h0001);
		convState = CONV_OFF;
		repeat (2) @(negedge ref_clk);
		chk(errorAmpReference, 16'h0000);
		reportAndStop();
	end
endmodule
